/* File: verilog/module_gate_pkg.sv */
/*
 * Constants for the peripheral clock-gating register bank: register indices,
 * implemented-bit masks, reset values and the enable vector layout.
 * Assumes a plain register port with a 2-bit word index and 16-bit data.
 */
package module_gate_pkg;

    localparam int ADDR_W = 2;
    localparam int DATA_W = 16;
    localparam int NUM_PERIPH = 27;

    // Register indices
    localparam logic [ADDR_W-1:0] GATE_CTRL_1_IDX = 2'h0;
    localparam logic [ADDR_W-1:0] GATE_CTRL_2_IDX = 2'h1;
    localparam logic [ADDR_W-1:0] GATE_CTRL_3_IDX = 2'h2;
    localparam logic [ADDR_W-1:0] GATE_CTRL_4_IDX = 2'h3;

    // Writable bits of each register; the rest hold zero
    localparam logic [DATA_W-1:0] GATE_CTRL_1_MASK = 16'hFEFB;
    localparam logic [DATA_W-1:0] GATE_CTRL_2_MASK = 16'h0F0F;
    localparam logic [DATA_W-1:0] GATE_CTRL_3_MASK = 16'h0422;
    localparam logic [DATA_W-1:0] GATE_CTRL_4_MASK = 16'h0008;

    localparam logic [DATA_W-1:0] GATE_CTRL_RESET = 16'h0000;

    // Field positions, register 1
    localparam int TIMER5_OFF_BIT = 15;
    localparam int TIMER4_OFF_BIT = 14;
    localparam int TIMER3_OFF_BIT = 13;
    localparam int TIMER2_OFF_BIT = 12;
    localparam int TIMER1_OFF_BIT = 11;
    localparam int QUAD_DECODER1_OFF_BIT = 10;
    localparam int PWM_UNIT_OFF_BIT = 9;
    localparam int I2C_PORT1_OFF_BIT = 7;
    localparam int UART_PORT2_OFF_BIT = 6;
    localparam int UART_PORT1_OFF_BIT = 5;
    localparam int SPI_PORT2_OFF_BIT = 4;
    localparam int SPI_PORT1_OFF_BIT = 3;
    localparam int CAN_UNIT_OFF_BIT = 1;
    localparam int ADC_UNIT_OFF_BIT = 0;
    // Register 2
    localparam int CAPTURE4_OFF_BIT = 11;
    localparam int CAPTURE3_OFF_BIT = 10;
    localparam int CAPTURE2_OFF_BIT = 9;
    localparam int CAPTURE1_OFF_BIT = 8;
    localparam int COMPARE4_OFF_BIT = 3;
    localparam int COMPARE3_OFF_BIT = 2;
    localparam int COMPARE2_OFF_BIT = 1;
    localparam int COMPARE1_OFF_BIT = 0;
    // Register 3
    localparam int COMPARATOR_UNIT_OFF_BIT = 10;
    localparam int QUAD_DECODER2_OFF_BIT = 5;
    localparam int I2C_PORT2_OFF_BIT = 1;
    // Register 4
    localparam int REF_CLOCK_GEN_OFF_BIT = 3;

    // Positions in the clock-enable vector
    localparam int EN_TIMER1 = 0;
    localparam int EN_TIMER2 = 1;
    localparam int EN_TIMER3 = 2;
    localparam int EN_TIMER4 = 3;
    localparam int EN_TIMER5 = 4;
    localparam int EN_QUAD_DECODER1 = 5;
    localparam int EN_PWM_UNIT = 6;
    localparam int EN_I2C_PORT1 = 7;
    localparam int EN_UART_PORT2 = 8;
    localparam int EN_UART_PORT1 = 9;
    localparam int EN_SPI_PORT2 = 10;
    localparam int EN_SPI_PORT1 = 11;
    localparam int EN_CAN_UNIT = 12;
    localparam int EN_ADC_UNIT = 13;
    localparam int EN_CAPTURE1 = 14;
    localparam int EN_CAPTURE2 = 15;
    localparam int EN_CAPTURE3 = 16;
    localparam int EN_CAPTURE4 = 17;
    localparam int EN_COMPARE1 = 18;
    localparam int EN_COMPARE2 = 19;
    localparam int EN_COMPARE3 = 20;
    localparam int EN_COMPARE4 = 21;
    localparam int EN_COMPARATOR_UNIT = 22;
    localparam int EN_QUAD_DECODER2 = 23;
    localparam int EN_I2C_PORT2 = 24;
    localparam int EN_REF_CLOCK_GEN = 25;
    localparam int EN_SPARE = 26;

    localparam logic [NUM_PERIPH-1:0] ALL_PRESENT = 27'h7FFFFFF;

endpackage

/* File: verilog/module_gate.sv */
/*
 * Peripheral clock-gating register bank: four 16-bit disable registers, one
 * registered clock-enable per peripheral, and a per-peripheral access permit
 * that blocks register traffic to gated peripherals.
 * Assumes a single clock, a synchronous active-low reset and a register port
 * whose master never waits; read data are valid only in the cycle after the
 * read strobe.
 */
// The placing of the registers and the plain strobed port were chosen for this implementation.
// Summary of operation
// - A peripheral whose disable bit is 1 has all of its clocks stopped.
// - A disabled peripheral ignores register writes and its reads are not valid.
// - A peripheral runs only if its disable bit is 0 and it is present in this variant.
// - After reset every implemented disable bit is 0, so present peripherals run.
// - Setting a disable bit stops the peripheral one cycle after the write.
// - Clearing a disable bit restarts the peripheral one cycle after the write.
// - Register 1 bits 15..11 gate timers 5..1, bit 10 decoder 1, bit 9 the PWM unit; bit 8 is absent.
// - Register 1 bits 7,6,5,4,3,1,0 gate I2C 1, UART 2, UART 1, SPI 2, SPI 1, CAN and ADC; bit 2 is absent.
// - Register 2 bits 11..8 gate capture 4..1 and bits 3..0 gate compare 4..1.
// - Register 3 bit 10 gates the comparator unit, bit 5 decoder 2, bit 1 I2C port 2.
// - Register 4 bit 3 alone gates the reference clock generator.
// - Unimplemented bits ignore writes and read as zero.
`timescale 1ns/10ps

module module_gate
    import module_gate_pkg::*;
#(
    parameter logic [NUM_PERIPH-1:0] PRESENT = ALL_PRESENT
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [DATA_W-1:0]     reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [DATA_W-1:0]     reg_rdata,
    output logic      [NUM_PERIPH-1:0] periph_clk_en,
    output logic      [NUM_PERIPH-1:0] periph_access_en
);

    logic [DATA_W-1:0]     gate_ctrl_1_reg;
    logic [DATA_W-1:0]     gate_ctrl_2_reg;
    logic [DATA_W-1:0]     gate_ctrl_3_reg;
    logic [DATA_W-1:0]     gate_ctrl_4_reg;
    logic [NUM_PERIPH-1:0] off_vec;
    logic [NUM_PERIPH-1:0] run_next;

    // Register writes; masking keeps absent bits at zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            gate_ctrl_1_reg <= GATE_CTRL_RESET;
            gate_ctrl_2_reg <= GATE_CTRL_RESET;
            gate_ctrl_3_reg <= GATE_CTRL_RESET;
            gate_ctrl_4_reg <= GATE_CTRL_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                GATE_CTRL_1_IDX: gate_ctrl_1_reg <= reg_wdata & GATE_CTRL_1_MASK;
                GATE_CTRL_2_IDX: gate_ctrl_2_reg <= reg_wdata & GATE_CTRL_2_MASK;
                GATE_CTRL_3_IDX: gate_ctrl_3_reg <= reg_wdata & GATE_CTRL_3_MASK;
                GATE_CTRL_4_IDX: gate_ctrl_4_reg <= reg_wdata & GATE_CTRL_4_MASK;
                default: ;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= GATE_CTRL_RESET;
        end else if (reg_read) begin
            case (reg_addr)
                GATE_CTRL_1_IDX: reg_rdata <= gate_ctrl_1_reg;
                GATE_CTRL_2_IDX: reg_rdata <= gate_ctrl_2_reg;
                GATE_CTRL_3_IDX: reg_rdata <= gate_ctrl_3_reg;
                GATE_CTRL_4_IDX: reg_rdata <= gate_ctrl_4_reg;
                default:         reg_rdata <= GATE_CTRL_RESET;
            endcase
        end else begin
            reg_rdata <= GATE_CTRL_RESET;
        end
    end

    // Map register fields onto the enable vector
    always_comb begin
        off_vec = '0;
        off_vec[EN_TIMER5]          = gate_ctrl_1_reg[TIMER5_OFF_BIT];
        off_vec[EN_TIMER4]          = gate_ctrl_1_reg[TIMER4_OFF_BIT];
        off_vec[EN_TIMER3]          = gate_ctrl_1_reg[TIMER3_OFF_BIT];
        off_vec[EN_TIMER2]          = gate_ctrl_1_reg[TIMER2_OFF_BIT];
        off_vec[EN_TIMER1]          = gate_ctrl_1_reg[TIMER1_OFF_BIT];
        off_vec[EN_QUAD_DECODER1]   = gate_ctrl_1_reg[QUAD_DECODER1_OFF_BIT];
        off_vec[EN_PWM_UNIT]        = gate_ctrl_1_reg[PWM_UNIT_OFF_BIT];
        off_vec[EN_I2C_PORT1]       = gate_ctrl_1_reg[I2C_PORT1_OFF_BIT];
        off_vec[EN_UART_PORT2]      = gate_ctrl_1_reg[UART_PORT2_OFF_BIT];
        off_vec[EN_UART_PORT1]      = gate_ctrl_1_reg[UART_PORT1_OFF_BIT];
        off_vec[EN_SPI_PORT2]       = gate_ctrl_1_reg[SPI_PORT2_OFF_BIT];
        off_vec[EN_SPI_PORT1]       = gate_ctrl_1_reg[SPI_PORT1_OFF_BIT];
        off_vec[EN_CAN_UNIT]        = gate_ctrl_1_reg[CAN_UNIT_OFF_BIT];
        off_vec[EN_ADC_UNIT]        = gate_ctrl_1_reg[ADC_UNIT_OFF_BIT];
        off_vec[EN_CAPTURE4]        = gate_ctrl_2_reg[CAPTURE4_OFF_BIT];
        off_vec[EN_CAPTURE3]        = gate_ctrl_2_reg[CAPTURE3_OFF_BIT];
        off_vec[EN_CAPTURE2]        = gate_ctrl_2_reg[CAPTURE2_OFF_BIT];
        off_vec[EN_CAPTURE1]        = gate_ctrl_2_reg[CAPTURE1_OFF_BIT];
        off_vec[EN_COMPARE4]        = gate_ctrl_2_reg[COMPARE4_OFF_BIT];
        off_vec[EN_COMPARE3]        = gate_ctrl_2_reg[COMPARE3_OFF_BIT];
        off_vec[EN_COMPARE2]        = gate_ctrl_2_reg[COMPARE2_OFF_BIT];
        off_vec[EN_COMPARE1]        = gate_ctrl_2_reg[COMPARE1_OFF_BIT];
        off_vec[EN_COMPARATOR_UNIT] = gate_ctrl_3_reg[COMPARATOR_UNIT_OFF_BIT];
        off_vec[EN_QUAD_DECODER2]   = gate_ctrl_3_reg[QUAD_DECODER2_OFF_BIT];
        off_vec[EN_I2C_PORT2]       = gate_ctrl_3_reg[I2C_PORT2_OFF_BIT];
        off_vec[EN_REF_CLOCK_GEN]   = gate_ctrl_4_reg[REF_CLOCK_GEN_OFF_BIT];
        // Spare slot has no control bit, so it follows presence alone
        off_vec[EN_SPARE]           = 1'b0;
        run_next = ~off_vec & PRESENT;
    end

    // One stage per peripheral, one flop after the register: a write takes effect one cycle later
    // Enable and access permit load together, so a gated peripheral never accepts writes
    gate_stage timer1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_TIMER1]),
        .clk_en    (periph_clk_en[EN_TIMER1]),
        .access_en (periph_access_en[EN_TIMER1])
    );
    gate_stage timer2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_TIMER2]),
        .clk_en    (periph_clk_en[EN_TIMER2]),
        .access_en (periph_access_en[EN_TIMER2])
    );
    gate_stage timer3_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_TIMER3]),
        .clk_en    (periph_clk_en[EN_TIMER3]),
        .access_en (periph_access_en[EN_TIMER3])
    );
    gate_stage timer4_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_TIMER4]),
        .clk_en    (periph_clk_en[EN_TIMER4]),
        .access_en (periph_access_en[EN_TIMER4])
    );
    gate_stage timer5_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_TIMER5]),
        .clk_en    (periph_clk_en[EN_TIMER5]),
        .access_en (periph_access_en[EN_TIMER5])
    );
    gate_stage quad_decoder1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_QUAD_DECODER1]),
        .clk_en    (periph_clk_en[EN_QUAD_DECODER1]),
        .access_en (periph_access_en[EN_QUAD_DECODER1])
    );
    gate_stage pwm_unit_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_PWM_UNIT]),
        .clk_en    (periph_clk_en[EN_PWM_UNIT]),
        .access_en (periph_access_en[EN_PWM_UNIT])
    );
    gate_stage i2c_port1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_I2C_PORT1]),
        .clk_en    (periph_clk_en[EN_I2C_PORT1]),
        .access_en (periph_access_en[EN_I2C_PORT1])
    );
    gate_stage uart_port2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_UART_PORT2]),
        .clk_en    (periph_clk_en[EN_UART_PORT2]),
        .access_en (periph_access_en[EN_UART_PORT2])
    );
    gate_stage uart_port1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_UART_PORT1]),
        .clk_en    (periph_clk_en[EN_UART_PORT1]),
        .access_en (periph_access_en[EN_UART_PORT1])
    );
    gate_stage spi_port2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_SPI_PORT2]),
        .clk_en    (periph_clk_en[EN_SPI_PORT2]),
        .access_en (periph_access_en[EN_SPI_PORT2])
    );
    gate_stage spi_port1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_SPI_PORT1]),
        .clk_en    (periph_clk_en[EN_SPI_PORT1]),
        .access_en (periph_access_en[EN_SPI_PORT1])
    );
    gate_stage can_unit_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_CAN_UNIT]),
        .clk_en    (periph_clk_en[EN_CAN_UNIT]),
        .access_en (periph_access_en[EN_CAN_UNIT])
    );
    gate_stage adc_unit_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_ADC_UNIT]),
        .clk_en    (periph_clk_en[EN_ADC_UNIT]),
        .access_en (periph_access_en[EN_ADC_UNIT])
    );
    gate_stage capture1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_CAPTURE1]),
        .clk_en    (periph_clk_en[EN_CAPTURE1]),
        .access_en (periph_access_en[EN_CAPTURE1])
    );
    gate_stage capture2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_CAPTURE2]),
        .clk_en    (periph_clk_en[EN_CAPTURE2]),
        .access_en (periph_access_en[EN_CAPTURE2])
    );
    gate_stage capture3_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_CAPTURE3]),
        .clk_en    (periph_clk_en[EN_CAPTURE3]),
        .access_en (periph_access_en[EN_CAPTURE3])
    );
    gate_stage capture4_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_CAPTURE4]),
        .clk_en    (periph_clk_en[EN_CAPTURE4]),
        .access_en (periph_access_en[EN_CAPTURE4])
    );
    gate_stage compare1_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_COMPARE1]),
        .clk_en    (periph_clk_en[EN_COMPARE1]),
        .access_en (periph_access_en[EN_COMPARE1])
    );
    gate_stage compare2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_COMPARE2]),
        .clk_en    (periph_clk_en[EN_COMPARE2]),
        .access_en (periph_access_en[EN_COMPARE2])
    );
    gate_stage compare3_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_COMPARE3]),
        .clk_en    (periph_clk_en[EN_COMPARE3]),
        .access_en (periph_access_en[EN_COMPARE3])
    );
    gate_stage compare4_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_COMPARE4]),
        .clk_en    (periph_clk_en[EN_COMPARE4]),
        .access_en (periph_access_en[EN_COMPARE4])
    );
    gate_stage comparator_unit_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_COMPARATOR_UNIT]),
        .clk_en    (periph_clk_en[EN_COMPARATOR_UNIT]),
        .access_en (periph_access_en[EN_COMPARATOR_UNIT])
    );
    gate_stage quad_decoder2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_QUAD_DECODER2]),
        .clk_en    (periph_clk_en[EN_QUAD_DECODER2]),
        .access_en (periph_access_en[EN_QUAD_DECODER2])
    );
    gate_stage i2c_port2_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_I2C_PORT2]),
        .clk_en    (periph_clk_en[EN_I2C_PORT2]),
        .access_en (periph_access_en[EN_I2C_PORT2])
    );
    gate_stage ref_clock_gen_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_REF_CLOCK_GEN]),
        .clk_en    (periph_clk_en[EN_REF_CLOCK_GEN]),
        .access_en (periph_access_en[EN_REF_CLOCK_GEN])
    );
    gate_stage spare_stage_u (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (run_next[EN_SPARE]),
        .clk_en    (periph_clk_en[EN_SPARE]),
        .access_en (periph_access_en[EN_SPARE])
    );

endmodule

// One peripheral's gate: clock enable and access permit, both from flops
module gate_stage (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      clk_en,
    output logic      access_en
);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            clk_en <= 1'h0;
        end else begin
            clk_en <= run;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            access_en <= 1'h0;
        end else begin
            access_en <= run;
        end
    end

endmodule

/* File: bench/module_gate_properties.sv */
/* Port-level assertions for the clock-gating register bank.
   Assumes it is bound onto module_gate with the same PRESENT value. */
`timescale 1ns/10ps
module module_gate_properties
    import module_gate_pkg::*;
#(
    parameter logic [NUM_PERIPH-1:0] PRESENT = ALL_PRESENT
) (
    input wire logic [0:0]            mclk,
    input wire logic [0:0]            reset_n,
    input wire logic [ADDR_W-1:0]     reg_addr,
    input wire logic [DATA_W-1:0]     reg_wdata,
    input wire logic [0:0]            reg_write,
    input wire logic [0:0]            reg_read,
    input wire logic [DATA_W-1:0]     reg_rdata,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en,
    input wire logic [NUM_PERIPH-1:0] periph_access_en
);
    localparam logic [DATA_W-1:0] MASKS [4] = '{GATE_CTRL_1_MASK, GATE_CTRL_2_MASK,
                                                GATE_CTRL_3_MASK, GATE_CTRL_4_MASK};
    wire logic [DATA_W-1:0] mask = MASKS[reg_addr];
    wire logic              w1   = reg_write && reg_addr == GATE_CTRL_1_IDX;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_ACCESS_SAME: assert property (periph_access_en == periph_clk_en)
        else $error("access permit differs");
    AST_ABSENT_OFF: assert property ((periph_clk_en & ~PRESENT) == '0)
        else $error("absent peripheral enabled");
    AST_RDATA_MASK: assert property (reg_read |=> (reg_rdata & ~$past(mask)) == '0)
        else $error("unimplemented bit read as one");
    AST_TIMER1_OFF: assert property (w1 && reg_wdata[TIMER1_OFF_BIT] |-> ##2 !periph_access_en[EN_TIMER1])
        else $error("timer1 still enabled");
    AST_SET_LATE: assert property (w1 && reg_wdata[TIMER5_OFF_BIT] |-> ##2 !periph_clk_en[EN_TIMER5])
        else $error("timer5 not gated in time");
    AST_SET_NOT_EARLY: assert property (w1 && reg_wdata[TIMER5_OFF_BIT] && periph_clk_en[EN_TIMER5]
        && !($past(w1) && $past(reg_wdata[TIMER5_OFF_BIT])) |=> periph_clk_en[EN_TIMER5])
        else $error("timer5 gated too early");
    AST_CLEAR: assert property (reg_write && reg_addr == GATE_CTRL_2_IDX && !reg_wdata[CAPTURE1_OFF_BIT]
        |-> ##2 periph_clk_en[EN_CAPTURE1] == PRESENT[EN_CAPTURE1])
        else $error("capture1 not restarted");
    AST_REF_GATE: assert property (reg_write && reg_addr == GATE_CTRL_4_IDX && reg_wdata[REF_CLOCK_GEN_OFF_BIT]
        |-> ##2 !periph_clk_en[EN_REF_CLOCK_GEN])
        else $error("reference generator not gated");
    AST_EN_STABLE: assert property (!reg_write |-> ##2 $stable(periph_clk_en))
        else $error("enable moved without a write");
endmodule
bind module_gate module_gate_properties #(.PRESENT(PRESENT)) chk_u (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .periph_clk_en(periph_clk_en), .periph_access_en(periph_access_en));

/* File: bench/test_module_gate.sv */
/* Self-checking bench for the clock-gating register bank.
   Assumes the package and the checker are compiled before it. */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, g, e); end end
module test_module_gate
    import module_gate_pkg::*;
;
    // Timer4 absent, so presence gating is exercised
    localparam logic [NUM_PERIPH-1:0] PRES = ALL_PRESENT & 27'h7FFFFF7;
    localparam logic [DATA_W-1:0]     MASKS [4] = '{GATE_CTRL_1_MASK, GATE_CTRL_2_MASK,
                                                    GATE_CTRL_3_MASK, GATE_CTRL_4_MASK};
    logic                  mclk = 1'h0, reset_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0, rd_q = 1'h0;
    logic [ADDR_W-1:0]     reg_addr = '0;
    logic [DATA_W-1:0]     reg_wdata = '0, reg_rdata, exp_d;
    logic [DATA_W-1:0]     exp_r [4], sh [4];
    logic [DATA_W-1:0]     q [$];
    logic [NUM_PERIPH-1:0] clk_en, acc_en, en_m;
    logic [31:0]           seed = 32'h3BCD, r;
    int                    fails = 0, checks_done = 0, cyc = 0;
    always #4 mclk = ~mclk;
    module_gate #(.PRESENT(PRES)) dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .periph_clk_en(clk_en),
        .periph_access_en(acc_en));
    function automatic logic [NUM_PERIPH-1:0] offv(input logic [DATA_W-1:0] a, b, c, d);
        return {1'h0, d[3], c[1], c[5], c[10], b[3:0], b[11:8],
                a[0], a[1], a[3], a[4], a[5], a[6], a[7], a[9], a[10], a[15:11]};
    endfunction
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        reg_read <= 1'h0;
        exp_r[a] = d & MASKS[a];
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_write <= 1'h0;
        reg_read <= 1'h1;
        q.push_back(exp_r[a]);
    endtask
    task automatic idle();
        @(posedge mclk);
        reg_write <= 1'h0;
        reg_read <= 1'h0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog past 2000 cycles; the mirror of the bank below lags the register by one cycle of enable
    always @(posedge mclk) begin
        if (cyc > 2000) begin
            fails++;
            end_sim();
        end
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        exp_d = rd_q ? q.pop_front() : 16'h0000;
        if (cyc > 0) begin
            `CHK(acc_en, clk_en)
            `CHK(clk_en, en_m)
            `CHK(reg_rdata, exp_d)
        end
        rd_q <= reg_read && reset_n;
        en_m <= reset_n ? ~offv(sh[0], sh[1], sh[2], sh[3]) & PRES : '0;
        if (!reset_n) sh <= '{default: '0};
        else if (reg_write) sh[reg_addr] <= reg_wdata & MASKS[reg_addr];
    end
    initial begin
        exp_r = '{default: '0};
        repeat (3) @(posedge mclk);
        reset_n <= 1'h1;
        for (int a = 0; a < 4; a++) rd(a[1:0]);
        for (int a = 0; a < 4; a++) begin
            wr(a[1:0], 16'hFFFF);
            rd(a[1:0]);
            for (int b = 0; b < 16; b++) begin
                wr(a[1:0], 16'h0001 << b);
                rd(a[1:0]);
            end
            wr(a[1:0], 16'h0000);
            idle();
        end
        // PWM unit gated and released; random register traffic follows
        wr(2'h0, 16'h0200);
        wr(2'h0, 16'h0000);
        idle();
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            if (r[31]) wr(r[1:0], r[23:8]);
            else rd(r[1:0]);
        end
        wr(2'h0, 16'hFFFF);
        idle();
        idle();
        reset_n <= 1'h0;
        exp_r = '{default: '0};
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        rd(2'h0);
        idle();
        repeat (3) @(posedge mclk);
        `CHK(q.size(), 0)
        end_sim();
    end
endmodule
